//--- wdg_service_pkg.sv
package wdg_service_pkg;

    // Register location and field layout of the service/disable register.
    localparam logic [6:0] SERVICE_REG_ADDR = 7'h0a;
    localparam int REG_WIDTH = 16;
    localparam int FLAG_POS = 4;
    localparam int OUTCOME_LSB = 1;
    localparam int PARITY_POS = 0;
    localparam logic [15:0] SERVICE_REG_RESET = 16'h0000;

    // Frame layout: write flag, seven address bits, sixteen data bits.
    localparam int FRAME_BITS = 24;
    localparam int HEADER_BITS = 8;

    // Key and trigger words as seen in bits 15:1 of a write.
    localparam logic [14:0] TRIGGER_FIRST = 15'h5555;
    localparam logic [14:0] TRIGGER_SECOND = 15'h2aaa;
    localparam logic [14:0] DISABLE_KEY_FIRST = 15'h2f6b;
    localparam logic [14:0] DISABLE_KEY_SECOND = 15'h1097;

    // Outcome codes reported for the most recent write.
    localparam logic [2:0] OUT_NONE = 3'h0;
    localparam logic [2:0] OUT_TRIGGER_OK = 3'h1;
    localparam logic [2:0] OUT_FAULT = 3'h2;
    localparam logic [2:0] OUT_KEY_FIRST = 3'h3;
    localparam logic [2:0] OUT_FIRST_TRIGGER = 3'h5;
    localparam logic [2:0] OUT_DISABLED = 3'h7;

    // Odd parity: bit 0 makes the count of ones in the word odd.
    localparam logic PARITY_ODD = 1'b1;

    typedef enum logic [1:0] {
        ST_TURN_ON = 2'b00,
        ST_WINDOW = 2'b01,
        ST_KEY_FIRST = 2'b10,
        ST_DISABLED = 2'b11
    } wdg_state_type;

    typedef struct packed {
        logic write;
        logic [6:0] addr;
        logic [15:0] data;
    } spi_frame_type;

    function automatic logic parity_of(input logic [14:0] bits);
        parity_of = (^bits) ^ PARITY_ODD;
    endfunction : parity_of

endpackage : wdg_service_pkg

//--- wdg_spi_frame.sv
`timescale 1ns/1ps
`default_nettype none

module wdg_spi_frame
    import wdg_service_pkg::*;
#(
    parameter logic [6:0] MATCH_ADDR = SERVICE_REG_ADDR
)
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Synchronised serial lines.
    input wire logic i_sck,
    input wire logic i_csn,
    input wire logic i_sdi,
    // Read-back word offered when the header selects this register.
    input wire logic [15:0] i_read_word,
    // Serial output.
    output logic o_sdo,
    output logic o_sdo_oe,
    // Completed frame.
    output logic o_frame_valid,
    output wdg_service_pkg::spi_frame_type o_frame
);
    import wdg_service_pkg::*;

    logic sck_d;
    logic csn_d;
    logic [4:0] bit_count;
    logic [FRAME_BITS-1:0] rx_shift;
    logic [15:0] tx_shift;
    logic selected;
    logic sck_rise;
    logic sck_fall;
    logic csn_rise;

    assign sck_rise = i_sck && !sck_d && !i_csn;
    assign sck_fall = !i_sck && sck_d && !i_csn;
    assign csn_rise = i_csn && !csn_d;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sck_d <= 1'b0;
            csn_d <= 1'b1;
        end
        else
        begin
            sck_d <= i_sck;
            csn_d <= i_csn;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            bit_count <= 5'h00;
            rx_shift <= '0;
        end
        else if (i_csn)
        begin
            bit_count <= 5'h00;
        end
        else if (sck_rise)
        begin
            rx_shift <= {rx_shift[FRAME_BITS-2:0], i_sdi};
            if (bit_count != 5'h1f)
            begin
                bit_count <= bit_count + 5'h01;
            end
        end
    end

    // The data phase is driven only when the header addresses this register.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            selected <= 1'b0;
            tx_shift <= 16'h0000;
            o_sdo <= 1'b0;
        end
        else if (i_csn)
        begin
            selected <= 1'b0;
            o_sdo <= 1'b0;
        end
        else if (sck_rise && bit_count == 5'(HEADER_BITS - 1))
        begin
            // The last address bit arrives on this very edge, so it is taken from the pin.
            selected <= ({rx_shift[5:0], i_sdi} == MATCH_ADDR);
            tx_shift <= i_read_word;
        end
        else if (sck_fall && selected)
        begin
            o_sdo <= tx_shift[15];
            tx_shift <= {tx_shift[14:0], 1'b0};
        end
    end

    assign o_sdo_oe = selected && !i_csn;

    // Only frames of exactly twenty-four bits are handed on.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_frame_valid <= 1'b0;
            o_frame <= '0;
        end
        else
        begin
            o_frame_valid <= csn_rise && bit_count == 5'(FRAME_BITS);
            if (csn_rise)
            begin
                o_frame <= rx_shift;
            end
        end
    end

endmodule : wdg_spi_frame

`default_nettype wire

//--- watchdog_service_and_disable.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - Upper byte always reads zero.
// - Bits 7..5 zero; status, outcome, parity below.
// - Disabled flag set on disable, cleared on enable.
// - Outcome field reflects the latest register write, except writes while disabled.
// - Second key 1097h reports outcome 111.
// - Transfer between keys aborts and raises fault.
// - First trigger 5555h starts window mode.
// - Disable needs 2F6Bh then 1097h, else fault.
module watchdog_service_and_disable
    import wdg_service_pkg::*;
(
    // Clock and reset.
    input wire logic I_CLK_SYS,
    input wire logic I_NRST,
    // Serial port pins.
    input wire logic I_SPI_SCK,
    input wire logic I_SPI_CSN,
    input wire logic I_SPI_SDI,
    output logic O_SPI_SDO,
    output logic O_SPI_SDO_OE,
    // Watchdog control and state.
    input wire logic I_WDG_ENABLE,
    output logic O_WDG_FAULT,
    output logic O_WDG_DISABLED,
    output logic O_WDG_WINDOW_MODE
);
    import wdg_service_pkg::*;

    logic [1:0] rst_sync;
    logic rst_n;
    logic [1:0] sck_sync;
    logic [1:0] csn_sync;
    logic [1:0] sdi_sync;
    logic frame_valid;
    spi_frame_type frame;
    wdg_state_type state;
    wdg_state_type next_state;
    logic [2:0] outcome;
    logic [2:0] next_outcome;
    logic next_fault;
    logic watchdog_disabled_flag;
    logic [14:0] expected_trigger;
    logic [15:0] read_word;
    logic reg_write;
    logic [14:0] watchdog_write_word;
    logic disable_done;

    always_ff @(posedge I_CLK_SYS or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            rst_sync <= 2'b00;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];

    always_ff @(posedge I_CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sck_sync <= 2'b00;
            csn_sync <= 2'b11;
            sdi_sync <= 2'b00;
        end
        else
        begin
            sck_sync <= {sck_sync[0], I_SPI_SCK};
            csn_sync <= {csn_sync[0], I_SPI_CSN};
            sdi_sync <= {sdi_sync[0], I_SPI_SDI};
        end
    end

    wdg_spi_frame #(
        .MATCH_ADDR(SERVICE_REG_ADDR)
    ) u_frame (
        .i_clk(I_CLK_SYS),
        .i_rst_n(rst_n),
        .i_sck(sck_sync[1]),
        .i_csn(csn_sync[1]),
        .i_sdi(sdi_sync[1]),
        .i_read_word(read_word),
        .o_sdo(O_SPI_SDO),
        .o_sdo_oe(O_SPI_SDO_OE),
        .o_frame_valid(frame_valid),
        .o_frame(frame)
    );

    assign reg_write = frame_valid && frame.write && frame.addr == SERVICE_REG_ADDR;
    assign watchdog_write_word = frame.data[15:1];

    // Read-back word with reserved bits forced to zero.
    always_comb
    begin
        read_word = SERVICE_REG_RESET;
        read_word[FLAG_POS] = watchdog_disabled_flag;
        read_word[OUTCOME_LSB +: 3] = outcome;
        read_word[PARITY_POS] = parity_of(read_word[15:1]);
    end

    always_comb
    begin
        next_state = state;
        next_outcome = outcome;
        next_fault = 1'b0;
        if (frame_valid && state == ST_KEY_FIRST)
        begin
            if (reg_write && watchdog_write_word == DISABLE_KEY_SECOND)
            begin
                next_state = ST_DISABLED;
                next_outcome = OUT_DISABLED;
            end
            else
            begin
                // Any other transfer between the keys aborts.
                next_state = ST_WINDOW;
                next_fault = 1'b1;
                if (reg_write)
                begin
                    next_outcome = OUT_FAULT;
                end
            end
        end
        else if (reg_write)
        begin
            case (state)
                ST_TURN_ON:
                begin
                    if (watchdog_write_word == TRIGGER_FIRST)
                    begin
                        next_state = ST_WINDOW;
                        next_outcome = OUT_FIRST_TRIGGER;
                    end
                    else
                    begin
                        next_fault = 1'b1;
                        next_outcome = OUT_FAULT;
                    end
                end
                ST_WINDOW:
                begin
                    if (watchdog_write_word == expected_trigger)
                    begin
                        next_outcome = OUT_TRIGGER_OK;
                    end
                    else if (watchdog_write_word == DISABLE_KEY_FIRST)
                    begin
                        next_state = ST_KEY_FIRST;
                        next_outcome = OUT_KEY_FIRST;
                    end
                    else
                    begin
                        next_fault = 1'b1;
                        next_outcome = OUT_FAULT;
                    end
                end
                default:
                begin
                    next_state = state;
                end
            endcase
        end
        if (I_WDG_ENABLE && next_state == ST_DISABLED && state == ST_DISABLED)
        begin
            next_state = ST_TURN_ON;
        end
    end

    assign disable_done = next_state == ST_DISABLED && state == ST_KEY_FIRST;

    always_ff @(posedge I_CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_TURN_ON;
            outcome <= OUT_NONE;
            O_WDG_FAULT <= 1'b0;
        end
        else
        begin
            state <= next_state;
            outcome <= next_outcome;
            O_WDG_FAULT <= next_fault;
        end
    end

    // Completion of the disable sequence wins over a simultaneous enable.
    always_ff @(posedge I_CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            watchdog_disabled_flag <= 1'b0;
        end
        else if (disable_done)
        begin
            watchdog_disabled_flag <= 1'b1;
        end
        else if (I_WDG_ENABLE)
        begin
            watchdog_disabled_flag <= 1'b0;
        end
    end

    // Each accepted trigger must toggle every bit of the previous one.
    always_ff @(posedge I_CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            expected_trigger <= TRIGGER_SECOND;
        end
        else if (reg_write && state == ST_TURN_ON && watchdog_write_word == TRIGGER_FIRST)
        begin
            expected_trigger <= TRIGGER_SECOND;
        end
        else if (reg_write && state == ST_WINDOW && watchdog_write_word == expected_trigger)
        begin
            expected_trigger <= ~expected_trigger;
        end
    end

    assign O_WDG_DISABLED = watchdog_disabled_flag;
    assign O_WDG_WINDOW_MODE = state == ST_WINDOW || state == ST_KEY_FIRST;

    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!rst_n);

    a_upper_byte_zero: assert property (O_SPI_SDO_OE |-> read_word[15:8] == 8'h00)
        else $error("Upper byte of read-back word is not zero.");
    a_low_reserved_zero: assert property (read_word[7:5] == 3'h0)
        else $error("Reserved low bits of read-back word are not zero.");
    a_disable_sets_flag: assert property (
        frame_valid && state == ST_KEY_FIRST && reg_write
        && watchdog_write_word == DISABLE_KEY_SECOND
        |=> watchdog_disabled_flag && read_word[FLAG_POS] && state == ST_DISABLED)
        else $error("Disable flag not set after second key.");
    a_enable_clears_flag: assert property (
        I_WDG_ENABLE && !disable_done |=> !watchdog_disabled_flag)
        else $error("Disable flag not cleared on enable.");
    a_outcome_stable: assert property (!frame_valid |=> $stable(outcome))
        else $error("Outcome changed without a transfer.");
    a_first_trigger: assert property (
        state == ST_TURN_ON && reg_write && watchdog_write_word == TRIGGER_FIRST
        |=> outcome == 3'h5 && O_WDG_WINDOW_MODE && !O_WDG_FAULT)
        else $error("First trigger not reported as 101.");
    a_second_key: assert property (
        state == ST_KEY_FIRST && reg_write && watchdog_write_word == DISABLE_KEY_SECOND
        |=> read_word[3:1] == 3'h7)
        else $error("Second key not reported as 111.");
    a_abort_fault: assert property (
        state == ST_KEY_FIRST && frame_valid
        && !(reg_write && watchdog_write_word == DISABLE_KEY_SECOND)
        |=> O_WDG_FAULT && state == ST_WINDOW ##1 !O_WDG_FAULT)
        else $error("Interrupted disable sequence did not fault.");
    a_wrong_order: assert property (
        state == ST_WINDOW && reg_write && watchdog_write_word == DISABLE_KEY_SECOND
        |=> O_WDG_FAULT && !watchdog_disabled_flag)
        else $error("Second key before first key did not fault.");
    a_parity_odd: assert property (^read_word == PARITY_ODD)
        else $error("Read-back parity is wrong.");

    c_first_trigger: cover property (state == ST_TURN_ON ##1 state == ST_WINDOW);
    c_disable_done: cover property (state == ST_KEY_FIRST ##1 state == ST_DISABLED);
    c_abort: cover property (state == ST_KEY_FIRST ##1 O_WDG_FAULT);
    c_reenable: cover property (state == ST_DISABLED ##1 state == ST_TURN_ON);

endmodule : watchdog_service_and_disable

`default_nettype wire

//--- wdg_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module wdg_host_model
(
    // Clock.
    input wire logic i_clk,
    // Device answer.
    input wire logic i_sdo,
    input wire logic i_sdo_oe,
    // Serial lines driven by the host.
    output logic o_sck,
    output logic o_csn,
    output logic o_sdi
);
    logic oe_seen;

    initial
    begin
        o_sck = 1'b0;
        o_csn = 1'b1;
        o_sdi = 1'b0;
        oe_seen = 1'b0;
    end

    always @(posedge i_clk)
    begin
        if (i_sdo_oe)
        begin
            oe_seen <= 1'b1;
        end
    end

    // One mode 0 frame, MSB first; hp is the SCK half period in system clocks.
    // The nbits argument sends only the first bits of the frame, to make a cut frame.
    task automatic xfer(input logic [23:0] frame, input int hp, input int nbits,
        output logic [15:0] rd);
        rd = 16'h0000;
        @(posedge i_clk);
        oe_seen <= 1'b0;
        o_csn <= 1'b0;
        for (int i = 23; i > 23 - nbits; i--)
        begin
            o_sdi <= frame[i];
            repeat (hp) @(posedge i_clk);
            o_sck <= 1'b1;
            if (i < 16)
            begin
                // An undriven data line shows the inverse of its last level.
                rd[i] = i_sdo_oe ? i_sdo : ~i_sdo;
            end
            repeat (hp) @(posedge i_clk);
            o_sck <= 1'b0;
        end
        repeat (hp) @(posedge i_clk);
        o_csn <= 1'b1;
        // A released data line must not keep showing the last bit of a full frame.
        o_sdi <= ~frame[0];
        repeat (10) @(posedge i_clk);
    endtask : xfer
endmodule : wdg_host_model

`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, a, b); end end

module tb_top;
    import wdg_service_pkg::*;

    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic enable = 1'b0;
    logic sck, csn, sdi, sdo, sdo_oe, fault, disabled, window_mode;
    logic [31:0] lfsr = 32'h0bb6;
    logic [15:0] rd;
    int miscompares = 0;
    int tests_run = 0;
    int fault_count = 0;
    int fault_exp = 0;

    always #5 clk = ~clk;

    always @(posedge clk)
    begin
        if (fault === 1'b1)
        begin
            fault_count++;
        end
    end

    watchdog_service_and_disable uut (.I_CLK_SYS(clk), .I_NRST(nrst), .I_SPI_SCK(sck),
        .I_SPI_CSN(csn), .I_SPI_SDI(sdi), .O_SPI_SDO(sdo), .O_SPI_SDO_OE(sdo_oe),
        .I_WDG_ENABLE(enable), .O_WDG_FAULT(fault), .O_WDG_DISABLED(disabled),
        .O_WDG_WINDOW_MODE(window_mode));

    wdg_host_model host (.i_clk(clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe), .o_sck(sck),
        .o_csn(csn), .o_sdi(sdi));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // Expected read-back word: reserved zeros, flag, outcome, odd parity.
    function automatic logic [15:0] exp_word(input logic dis, input logic [2:0] outc);
        logic [14:0] b;
        b = {8'h00, 3'b000, dis, outc};
        return {b, ~(^b)};
    endfunction : exp_word

    task automatic frame(input logic wr_flag, input logic [6:0] addr, input logic [14:0] w);
        lfsr = lfsr_next(lfsr);
        host.xfer({wr_flag, addr, w, lfsr[0]}, 4 + int'(lfsr[2:1]), 24, rd);
    endtask : frame

    task automatic wr(input logic [14:0] w);
        frame(1'b1, SERVICE_REG_ADDR, w);
    endtask : wr

    task automatic rdchk(input logic dis, input logic [2:0] outc);
        lfsr = lfsr_next(lfsr);
        frame(1'b0, SERVICE_REG_ADDR, lfsr[14:0]);
        `CHK(rd, exp_word(dis, outc))
        `CHK(host.oe_seen, 1'b1)
        `CHK(fault_count, fault_exp)
    endtask : rdchk

    task automatic reset_dut();
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : reset_dut

    task automatic print_verdict();
        if (miscompares == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    initial
    begin
        #500000;
        miscompares++;
        print_verdict();
    end

    initial
    begin
        reset_dut();
        rdchk(1'b0, 3'b000);
        `CHK(window_mode, 1'b0)
        // A frame to another address must leave the data line undriven.
        lfsr = lfsr_next(lfsr);
        frame(1'b0, (lfsr[6:0] == SERVICE_REG_ADDR) ? 7'h0b : lfsr[6:0], lfsr[22:8]);
        `CHK(host.oe_seen, 1'b0)
        // A first write other than 5555h faults and stays in turn-on.
        wr(TRIGGER_SECOND);
        fault_exp++;
        rdchk(1'b0, 3'b010);
        `CHK(window_mode, 1'b0)
        wr(TRIGGER_FIRST);
        rdchk(1'b0, 3'b101);
        `CHK(window_mode, 1'b1)
        for (int k = 0; k < 6; k++)
        begin
            wr((k % 2 == 0) ? TRIGGER_SECOND : TRIGGER_FIRST);
            rdchk(1'b0, 3'b001);
        end
        // Second key without the first is out of order.
        wr(DISABLE_KEY_SECOND);
        fault_exp++;
        rdchk(1'b0, 3'b010);
        reset_dut();
        rdchk(1'b0, 3'b000);
        wr(TRIGGER_FIRST);
        rdchk(1'b0, 3'b101);
        // A read-back between the keys aborts the procedure.
        wr(DISABLE_KEY_FIRST);
        fault_exp++;
        rdchk(1'b0, 3'b011);
        `CHK(disabled, 1'b0)
        `CHK(window_mode, 1'b1)
        // A frame to any other address between the keys aborts as well.
        wr(DISABLE_KEY_FIRST);
        lfsr = lfsr_next(lfsr);
        frame(1'b1, (lfsr[6:0] == SERVICE_REG_ADDR) ? 7'h0c : lfsr[6:0], lfsr[22:8]);
        fault_exp++;
        rdchk(1'b0, 3'b011);
        `CHK(window_mode, 1'b1)
        wr(DISABLE_KEY_FIRST);
        wr(DISABLE_KEY_SECOND);
        rdchk(1'b1, 3'b111);
        `CHK(disabled, 1'b1)
        `CHK(window_mode, 1'b0)
        wr(TRIGGER_FIRST);
        rdchk(1'b1, 3'b111);
        @(posedge clk);
        enable <= 1'b1;
        @(posedge clk);
        enable <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(disabled, 1'b0)
        `CHK(window_mode, 1'b0)
        rdchk(1'b0, 3'b111);
        // A frame one bit short is dropped entirely.
        host.xfer({1'b1, SERVICE_REG_ADDR, TRIGGER_FIRST, 1'b0}, 5, 23, rd);
        rdchk(1'b0, 3'b111);
        `CHK(window_mode, 1'b0)
        wr(TRIGGER_FIRST);
        rdchk(1'b0, 3'b101);
        `CHK(window_mode, 1'b1)
        print_verdict();
    end
endmodule : tb_top

`default_nettype wire
